// >>> rfd_checker.sv
// rfd_checker.sv: concurrent checks on the ports of rfd_top, bound into it below
// assumes one mclk domain with synchronous active-high rst
`timescale 1ns/1ps
module rfd_checker #(
	parameter PMOS_W = 6
) (
	input wire logic              mclk,
	input wire logic              rst,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pready,
	input wire logic              antenna_pin_a,
	input wire logic [PMOS_W-1:0] pmos_conductance,
	input wire logic [3:0]        field_sense_threshold,
	input wire logic              soft_power_down,
	input wire logic              field_sense_amp_on,
	input wire logic              auto_anticollision_command,
	input wire logic              scheme_detect_run,
	input wire logic              field_present_pin,
	input wire logic              scheme_locked,
	input wire logic [1:0]        scheme_code,
	input wire logic              field_irq,
	input wire logic              field_wake
);
	default clocking cb @(posedge mclk); endclocking

	// no disable here: the reset state itself is what is checked
	a_reset_state:
	assert property (rst |=> !antenna_pin_a && pmos_conductance == '0
		&& field_sense_threshold == 4'h8) else $error("state after reset wrong");
	a_apb_answer:
	assert property (disable iff (rst) psel && !penable |=> pready && penable)
		else $error("no answer in access cycle");
	a_amp_pd:
	assert property (disable iff (rst) soft_power_down |=> !field_sense_amp_on)
		else $error("amplifier on in power-down");
	a_run_cmd:
	assert property (disable iff (rst) scheme_detect_run |-> $past(auto_anticollision_command))
		else $error("detector runs without command");
	a_detect_reset:
	assert property (disable iff (rst) !field_present_pin [*8] |-> !scheme_locked
		&& scheme_code == 2'h0) else $error("detector kept result without field");
	a_irq_rise:
	assert property (disable iff (rst) $rose(field_present_pin) |-> ##[2:4] field_irq)
		else $error("no interrupt on field");
	a_irq_pulse:
	assert property (disable iff (rst) field_irq |=> !field_irq)
		else $error("interrupt longer than one cycle");
	a_irq_cause:
	assert property (disable iff (rst) field_irq |-> $past(field_present_pin, 2))
		else $error("interrupt without field");
	a_wake_field:
	assert property (disable iff (rst) (soft_power_down && field_present_pin) [*8]
		|-> field_wake) else $error("no wake on field");
endmodule

bind rfd_top rfd_checker #(.PMOS_W(PMOS_W)) rfd_checker_i (
	.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
	.antenna_pin_a(antenna_pin_a), .pmos_conductance(pmos_conductance),
	.field_sense_threshold(field_sense_threshold), .soft_power_down(soft_power_down),
	.field_sense_amp_on(field_sense_amp_on), .scheme_detect_run(scheme_detect_run),
	.auto_anticollision_command(auto_anticollision_command),
	.field_present_pin(field_present_pin), .scheme_locked(scheme_locked),
	.scheme_code(scheme_code), .field_irq(field_irq), .field_wake(field_wake)
);

// >>> rfd_defs.vh
// rfd_defs.vh: register offsets, field positions, reset values and codes for the rf driver block
// assumes byte addressing on a 32-bit apb bus, one register per aligned word
`ifndef RFD_DEFS_VH
`define RFD_DEFS_VH

`define RFD_ADDR_W           8
`define RFD_OFS_DRV_CTRL     8'h00
`define RFD_OFS_PMOS_CW      8'h04
`define RFD_OFS_PMOS_MOD     8'h08
`define RFD_OFS_NMOS         8'h0c
`define RFD_OFS_SENSE_CFG    8'h10
`define RFD_OFS_MODE         8'h14
`define RFD_OFS_STATUS       8'h18

// driver control fields
`define RFD_DC_A_EN          0
`define RFD_DC_B_EN          1
`define RFD_DC_A_INV_ON      2
`define RFD_DC_A_INV_OFF     3
`define RFD_DC_B_INV_ON      4
`define RFD_DC_B_INV_OFF     5
`define RFD_DC_B_CW          6
`define RFD_DC_FORCE_FULL    7
`define RFD_DC_W             8

`define RFD_PMOS_W           6
`define RFD_NMOS_CW_LSB      0
`define RFD_NMOS_MOD_LSB     4
`define RFD_NMOS_FLD_W       4

// field sense config
`define RFD_SC_THR_LSB       0
`define RFD_SC_AMP_BIT       4

// mode register
`define RFD_MD_DET_OFF_BIT   0

`define RFD_RST_DRV_CTRL     8'h00
`define RFD_RST_PMOS_CW      6'h3f
`define RFD_RST_PMOS_MOD     6'h20
`define RFD_RST_NMOS         8'h88
`define RFD_RST_THR          4'h8
`define RFD_GS_OFF           6'h00

// scheme codes reported by the detector
`define RFD_SCH_NONE         2'h0
`define RFD_SCH_106          2'h1
`define RFD_SCH_212          2'h2
`define RFD_SCH_424          2'h3

`endif

// >>> rfd_field_model.sv
// rfd_field_model.sv: external reader field and the demodulated data it carries
// assumes the bench sets field_on and the data half period in mclk cycles
`timescale 1ns/1ps
module rfd_field_model (
	input  wire logic        mclk,
	input  wire logic        field_on,
	input  wire logic [15:0] half_per,
	output logic             field_present_pin = 1'b0,
	output logic             rx_data_pin = 1'b0
);
	logic [15:0] cnt_q = 16'h0;

	always @(posedge mclk) begin
		field_present_pin <= field_on;
		if (!field_on) begin
			cnt_q <= 16'h0;
			// no field: the demodulator only sees noise, never a held level
			rx_data_pin <= ~rx_data_pin;
		end else if (cnt_q >= half_per - 16'h1) begin
			cnt_q <= 16'h0;
			rx_data_pin <= ~rx_data_pin;
		end else begin
			cnt_q <= cnt_q + 16'h1;
		end
	end
endmodule

// >>> rfd_scheme_det.v
// rfd_scheme_det.v: data mode detector, classifies the bit period of the received stream
// assumes rx_bit is already synchronised; mclk is 27.12 MHz derived domain used as mclk here
`timescale 1ns/1ps
`include "rfd_defs.vh"
module rfd_scheme_det #(
	parameter CNT_W   = 10,
	parameter LIM_212 = 10'd96,
	parameter LIM_424 = 10'd48
) (
	mclk,
	rst,
	ce,
	run,
	rx_bit,
	scheme,
	locked
);
	input  wire       mclk;
	input  wire       rst;
	input  wire       ce;
	input  wire       run;
	input  wire       rx_bit;
	output reg  [1:0] scheme;
	output reg        locked;

	reg [CNT_W-1:0] cnt_q;
	reg             prev_q;
	reg             seen_q;

	// period measured between two edges of the received stream
	always @(posedge mclk) begin
		if (rst || !run) begin
			cnt_q  <= {CNT_W{1'b0}};
			prev_q <= 1'b0;
			seen_q <= 1'b0;
			scheme <= `RFD_SCH_NONE;
			locked <= 1'b0;
		end else if (ce) begin
			prev_q <= rx_bit;
			if (rx_bit != prev_q) begin
				cnt_q  <= {CNT_W{1'b0}};
				// the span before the first edge is partial, so that edge only opens the count
				seen_q <= 1'b1;
				if (!locked && seen_q) begin
					locked <= 1'b1;
					if (cnt_q < LIM_424)
						scheme <= `RFD_SCH_424;
					else if (cnt_q < LIM_212)
						scheme <= `RFD_SCH_212;
					else
						scheme <= `RFD_SCH_106;
				end
			end else if (cnt_q != {CNT_W{1'b1}}) begin
				cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule

// >>> rfd_sync.v
// rfd_sync.v: two-stage synchroniser for single-bit levels from outside the mclk domain
// assumes input is a slow level; first stage is read only by the second
`timescale 1ns/1ps
module rfd_sync (
	mclk,
	rst,
	ce,
	d,
	q
);
	input  wire mclk;
	input  wire rst;
	input  wire ce;
	input  wire d;
	output reg  q;

	reg meta_q;

	always @(posedge mclk) begin
		if (rst) begin
			meta_q <= 1'b0;
			q      <= 1'b0;
		end else if (ce) begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule

// >>> rfd_top.v
// rfd_top.v: antenna driver selection, conductance selection and field sense control
// assumes mclk is the 27.12 MHz oscillator clock; apb slave with zero wait states
// How it works
// - carrier is mclk divided by two, with an inverted copy available
// - invert-when-on bit drives the complement carrier onto that pin
// - driver a enable low forces off conductance on both arrays
// - envelope high selects pmos continuous-wave register value
// - envelope low selects pmos keying register value
// - nmos continuous-wave value is low nibble of nmos register, envelope high
// - nmos keying value is high nibble of nmos register, envelope low
// - full-depth keying with envelope low pulls pin a to zero
// - driver b continuous-wave bit keeps b output on carrier, conductance still follows envelope
// - one conductance set is shared by both drivers
// - 4-bit threshold, 1111 least sensitive, 0000 most sensitive
// - detected field raises an interrupt, and in soft power-down also wakes the device
// - amplifier enable bit set to 1 switches on the sense amplifier
// - soft power-down always switches the sense amplifier off
// - detector reports 106, 212 or 424 kbit scheme to the receiver
// - scheme detector runs only during the auto anticollision command
// - scheme detector resets while no external field is sensed
// - scheme detect disable bit stops the detector during anticollision
`timescale 1ns/1ps
`include "rfd_defs.vh"
module rfd_top #(
	parameter PMOS_W = `RFD_PMOS_W
) (
	mclk,
	rst,
	ce,
	psel,
	penable,
	pwrite,
	paddr,
	pwdata,
	prdata,
	pready,
	pslverr,
	envelope,
	field_present_pin,
	rx_data_pin,
	soft_power_down,
	auto_anticollision_command,
	antenna_pin_a,
	antenna_pin_b,
	pmos_conductance,
	nmos_conductance,
	field_sense_threshold,
	field_sense_amp_on,
	field_wake,
	field_irq,
	scheme_code,
	scheme_locked,
	scheme_detect_run
);
	input  wire                     mclk;
	input  wire                     rst;
	input  wire                     ce;
	input  wire                     psel;
	input  wire                     penable;
	input  wire                     pwrite;
	input  wire [`RFD_ADDR_W-1:0]   paddr;
	input  wire [31:0]              pwdata;
	output reg  [31:0]              prdata;
	output reg                      pready;
	output reg                      pslverr;
	input  wire                     envelope;
	input  wire                     field_present_pin;
	input  wire                     rx_data_pin;
	input  wire                     soft_power_down;
	input  wire                     auto_anticollision_command;
	output reg                      antenna_pin_a;
	output reg                      antenna_pin_b;
	output reg  [PMOS_W-1:0]        pmos_conductance;
	output reg  [3:0]               nmos_conductance;
	output reg  [3:0]               field_sense_threshold;
	output reg                      field_sense_amp_on;
	output reg                      field_wake;
	output reg                      field_irq;
	output reg  [1:0]               scheme_code;
	output reg                      scheme_locked;
	output reg                      scheme_detect_run;

	// software registers
	reg [`RFD_DC_W-1:0]     driver_control_reg_q;
	reg [PMOS_W-1:0]        pmos_carrier_conductance_reg_q;
	reg [PMOS_W-1:0]        pmos_keying_conductance_reg_q;
	reg [7:0]               nmos_conductance_reg_q;
	reg [3:0]               threshold_q;
	reg                     field_sense_amplifier_enable_q;
	reg                     scheme_detect_disable_q;

	// carrier and synchronised pins
	reg                     carrier_q;
	reg                     env_s1_q;
	reg                     env_q;
	reg                     field_prev_q;
	wire                    field_s;
	wire                    rx_s;
	wire                    carrier_inverted;
	wire [1:0]              det_scheme;
	wire                    det_locked;

	// driver a's enable gates both pins and the shared conductances
	wire driver_a_enable          = driver_control_reg_q[`RFD_DC_A_EN];
	wire driver_b_enable          = driver_control_reg_q[`RFD_DC_B_EN];
	wire driver_a_invert_when_on  = driver_control_reg_q[`RFD_DC_A_INV_ON];
	wire driver_a_invert_when_off = driver_control_reg_q[`RFD_DC_A_INV_OFF];
	wire driver_b_invert_when_on  = driver_control_reg_q[`RFD_DC_B_INV_ON];
	wire driver_b_invert_when_off = driver_control_reg_q[`RFD_DC_B_INV_OFF];
	wire driver_b_continuous_wave = driver_control_reg_q[`RFD_DC_B_CW];
	wire force_full_depth_keying  = driver_control_reg_q[`RFD_DC_FORCE_FULL];

	wire [3:0] nmos_carrier_field = nmos_conductance_reg_q[`RFD_NMOS_CW_LSB +: `RFD_NMOS_FLD_W];
	wire [3:0] nmos_keying_field  = nmos_conductance_reg_q[`RFD_NMOS_MOD_LSB +: `RFD_NMOS_FLD_W];

	wire apb_wr = psel && penable && pwrite;
	wire apb_rd = psel && !penable && !pwrite;

	function addr_known;
		input [`RFD_ADDR_W-1:0] a;
		begin
			case (a)
			`RFD_OFS_DRV_CTRL,
			`RFD_OFS_PMOS_CW,
			`RFD_OFS_PMOS_MOD,
			`RFD_OFS_NMOS,
			`RFD_OFS_SENSE_CFG,
			`RFD_OFS_MODE,
			`RFD_OFS_STATUS: addr_known = 1'b1;
			default: addr_known = 1'b0;
			endcase
		end
	endfunction

	// pin output for one driver: carrier, inverted carrier or low
	function pin_value;
		input car;
		input inv_on;
		input inv_off;
		input force_low;
		input env;
		begin
			if (force_low && !env)
				pin_value = 1'b0;
			else if (env)
				pin_value = inv_on ? ~car : car;
			else
				pin_value = inv_off ? ~car : car;
		end
	endfunction

	rfd_sync u_sync_field (
		.mclk (mclk),
		.rst  (rst),
		.ce   (ce),
		.d    (field_present_pin),
		.q    (field_s)
	);

	rfd_sync u_sync_rx (
		.mclk (mclk),
		.rst  (rst),
		.ce   (ce),
		.d    (rx_data_pin),
		.q    (rx_s)
	);

	always @(posedge mclk) begin
		if (rst)
			carrier_q <= 1'b0;
		else if (ce)
			carrier_q <= ~carrier_q;
	end
	assign carrier_inverted = ~carrier_q;

	// envelope may come from another domain, so it is synchronised like a pin
	// reset high so the carrier starts unmodulated rather than as a keying gap
	always @(posedge mclk) begin
		if (rst) begin
			env_s1_q <= 1'b1;
			env_q    <= 1'b1;
		end else if (ce) begin
			env_s1_q <= envelope;
			env_q    <= env_s1_q;
		end
	end

	// apb write side
	always @(posedge mclk) begin
		if (rst) begin
			driver_control_reg_q           <= `RFD_RST_DRV_CTRL;
			pmos_carrier_conductance_reg_q <= `RFD_RST_PMOS_CW;
			pmos_keying_conductance_reg_q  <= `RFD_RST_PMOS_MOD;
			nmos_conductance_reg_q         <= `RFD_RST_NMOS;
			threshold_q                    <= `RFD_RST_THR;
			field_sense_amplifier_enable_q <= 1'b0;
			scheme_detect_disable_q        <= 1'b0;
		end else if (ce && apb_wr) begin
			case (paddr)
			`RFD_OFS_DRV_CTRL:
				driver_control_reg_q <= pwdata[`RFD_DC_W-1:0];
			`RFD_OFS_PMOS_CW:
				pmos_carrier_conductance_reg_q <= pwdata[PMOS_W-1:0];
			`RFD_OFS_PMOS_MOD:
				pmos_keying_conductance_reg_q <= pwdata[PMOS_W-1:0];
			`RFD_OFS_NMOS:
				nmos_conductance_reg_q <= pwdata[7:0];
			`RFD_OFS_SENSE_CFG: begin
				threshold_q <= pwdata[`RFD_SC_THR_LSB +: 4];
				field_sense_amplifier_enable_q <= pwdata[`RFD_SC_AMP_BIT];
			end
			`RFD_OFS_MODE:
				scheme_detect_disable_q <= pwdata[`RFD_MD_DET_OFF_BIT];
			// status and unmapped offsets ignore writes
			default: ;
			endcase
		end
	end

	// apb answer: ready in the access cycle, read data prepared in setup
	// status samples live values, so two reads in a row may differ
	always @(posedge mclk) begin
		if (rst) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (ce) begin
			// one-cycle answer, never a wait state
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !addr_known(paddr);
			if (apb_rd) begin
				case (paddr)
				`RFD_OFS_DRV_CTRL:  prdata <= {24'h0, driver_control_reg_q};
				`RFD_OFS_PMOS_CW:   prdata <= {{(32-PMOS_W){1'b0}},
								pmos_carrier_conductance_reg_q};
				`RFD_OFS_PMOS_MOD:  prdata <= {{(32-PMOS_W){1'b0}},
								pmos_keying_conductance_reg_q};
				`RFD_OFS_NMOS:      prdata <= {24'h0, nmos_conductance_reg_q};
				`RFD_OFS_SENSE_CFG: prdata <= {27'h0, field_sense_amplifier_enable_q,
								threshold_q};
				`RFD_OFS_MODE:      prdata <= {31'h0, scheme_detect_disable_q};
				`RFD_OFS_STATUS:    prdata <= {26'h0, field_sense_amp_on, field_s,
								scheme_locked, scheme_code, env_q};
				default:            prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// drivers: registered so envelope and control changes land on a carrier edge
	always @(posedge mclk) begin
		if (rst) begin
			antenna_pin_a    <= 1'b0;
			antenna_pin_b    <= 1'b0;
			pmos_conductance <= `RFD_GS_OFF;
			nmos_conductance <= 4'h0;
		end else if (ce) begin
			// driver a off: both arrays off, pins parked low
			// pin level is left open when off; parking low keeps the antenna quiet
			if (!driver_a_enable) begin
				pmos_conductance <= `RFD_GS_OFF;
				nmos_conductance <= 4'h0;
				antenna_pin_a    <= 1'b0;
				antenna_pin_b    <= 1'b0;
			end else begin
				// one set shared by both drivers
				if (env_q) begin
					pmos_conductance <= pmos_carrier_conductance_reg_q;
					nmos_conductance <= nmos_carrier_field;
				end else begin
					pmos_conductance <= pmos_keying_conductance_reg_q;
					nmos_conductance <= nmos_keying_field;
				end
				// next carrier phase computed one edge ahead
				antenna_pin_a <= pin_value(carrier_inverted, driver_a_invert_when_on,
					driver_a_invert_when_off, force_full_depth_keying, env_q);
				// continuous-wave driver b ignores envelope
				// driver b also needs its own enable, or it is parked low
				if (!driver_b_enable)
					antenna_pin_b <= 1'b0;
				else if (driver_b_continuous_wave)
					antenna_pin_b <= driver_b_invert_when_on ? carrier_q
						: carrier_inverted;
				else
					antenna_pin_b <= pin_value(carrier_inverted, driver_b_invert_when_on,
						driver_b_invert_when_off, force_full_depth_keying, env_q);
			end
		end
	end

	// field sense controls and detector gating
	always @(posedge mclk) begin
		if (rst) begin
			field_sense_threshold <= `RFD_RST_THR;
			field_sense_amp_on    <= 1'b0;
			field_wake            <= 1'b0;
			field_irq             <= 1'b0;
			field_prev_q          <= 1'b0;
			scheme_detect_run     <= 1'b0;
			scheme_code           <= `RFD_SCH_NONE;
			scheme_locked         <= 1'b0;
		end else if (ce) begin
			// code passed through unchanged: a higher code is less sensitive
			field_sense_threshold <= threshold_q;
			// amplifier enable, forced off in power-down
			// the amplifier is not refused with low codes; that pairing is up to software
			field_sense_amp_on <= field_sense_amplifier_enable_q && !soft_power_down;
			field_prev_q <= field_s;
			// wake level while field seen in power-down, irq pulse on arrival
			// irq is a one-cycle pulse; whoever needs a sticky flag must latch it
			field_wake <= field_s && soft_power_down;
			field_irq  <= field_s && !field_prev_q;
			// only under anticollision field required disable bit
			// field_s is the synchronised sense output, so losing the field also
			// holds the detector in reset a few cycles later
			scheme_detect_run <= auto_anticollision_command && field_s
				&& !scheme_detect_disable_q;
			// scheme result passed to the receiver
			scheme_code   <= det_scheme;
			scheme_locked <= det_locked;
		end
	end

	rfd_scheme_det u_det (
		.mclk   (mclk),
		.rst    (rst),
		.ce     (ce),
		.run    (scheme_detect_run),
		.rx_bit (rx_s),
		.scheme (det_scheme),
		.locked (det_locked)
	);
endmodule

// >>> tb.sv
// tb.sv: self-checking bench for rfd_top with an apb master and a field model
// assumes a zero-wait apb slave and mclk at 100 MHz
`timescale 1ns/1ps
`include "rfd_defs.vh"
module tb;
	logic        mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, se, env = 1, fon = 0, pd = 0, ac = 0, ce = 1;
	logic        pa, pb, amp, wake, irq, lk, run, fp, rx;
	logic [5:0]  pm;
	logic [3:0]  nm, thr;
	logic [1:0]  sc;
	logic [15:0] half = 16'd128;
	int          err_total = 0, n_checks = 0;

	always #5 mclk = ~mclk;

	rfd_top rfd_top_i (.mclk(mclk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .envelope(env), .field_present_pin(fp), .rx_data_pin(rx),
		.soft_power_down(pd), .auto_anticollision_command(ac), .antenna_pin_a(pa),
		.antenna_pin_b(pb), .pmos_conductance(pm), .nmos_conductance(nm),
		.field_sense_threshold(thr), .field_sense_amp_on(amp), .field_wake(wake),
		.field_irq(irq), .scheme_code(sc), .scheme_locked(lk), .scheme_detect_run(run));
	rfd_field_model rfd_field_model_i (.mclk(mclk), .field_on(fon), .half_per(half),
		.field_present_pin(fp), .rx_data_pin(rx));

	task cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask
	// ends one idle edge after release so the next setup is a fresh assignment
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) chk("pready", 32'h1, 32'h0);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] e, input string s);
		apb(1'b0, a, 32'h0);
		chk(s, e, rd);
	endtask
	task pins(input logic ta, input logic tgb, input logic inv);
		logic a0, b0;
		a0 = pa;
		b0 = pb;
		cyc(1);
		chk("pin_a", {31'h0, ta & ~a0}, {31'h0, pa});
		chk("pin_b", {31'h0, tgb & ~b0}, {31'h0, pb});
		if (ta && tgb) chk("pin_b phase", {31'h0, pa ^ inv}, {31'h0, pb});
	endtask
	task wlock;
		int n;
		n = 0;
		while (lk !== 1'b1 && n < 3000) begin
			cyc(1);
			n++;
		end
	endtask

	task t_regs;
		chk("threshold", 32'h8, {28'h0, thr});
		rdchk(`RFD_OFS_DRV_CTRL, 32'h00, "ctrl");
		rdchk(`RFD_OFS_PMOS_CW, 32'h3f, "pmos_cw reg");
		rdchk(`RFD_OFS_PMOS_MOD, 32'h20, "pmos_mod reg");
		rdchk(`RFD_OFS_NMOS, 32'h88, "nmos reg");
		rdchk(`RFD_OFS_SENSE_CFG, 32'h08, "sense_cfg");
		apb(1'b0, 8'h1c, 32'h0);
		chk("slverr", 32'h1, {31'h0, se});
		chk("unmapped", 32'h0, rd);
	endtask
	task t_drive;
		logic a0;
		wr(`RFD_OFS_NMOS, 32'h5a);
		wr(`RFD_OFS_PMOS_MOD, 32'h11);
		wr(`RFD_OFS_DRV_CTRL, 32'h03);
		cyc(4);
		pins(1, 1, 0);
		chk("pmos cw", 32'h3f, {26'h0, pm});
		chk("nmos cw", 32'ha, {28'h0, nm});
		env <= 1'b0;
		cyc(4);
		chk("pmos mod", 32'h11, {26'h0, pm});
		chk("nmos mod", 32'h5, {28'h0, nm});
		env <= 1'b1;
		wr(`RFD_OFS_DRV_CTRL, 32'h07);
		cyc(4);
		pins(1, 1, 1);
		// clock enable low must hold pin a still
		ce <= 1'b0;
		cyc(2);
		a0 = pa;
		cyc(3);
		chk("pin_a frozen", {31'h0, a0}, {31'h0, pa});
		ce <= 1'b1;
		cyc(2);
		pins(1, 1, 1);
	endtask
	task t_force;
		wr(`RFD_OFS_DRV_CTRL, 32'hcb);
		env <= 1'b0;
		cyc(4);
		pins(0, 1, 0);
		env <= 1'b1;
		wr(`RFD_OFS_DRV_CTRL, 32'h01);
		cyc(4);
		chk("pmos one driver", 32'h3f, {26'h0, pm});
		chk("nmos one driver", 32'ha, {28'h0, nm});
		wr(`RFD_OFS_DRV_CTRL, 32'h02);
		cyc(4);
		chk("pmos off", {26'h0, `RFD_GS_OFF}, {26'h0, pm});
		chk("nmos off", 32'h0, {28'h0, nm});
		pins(0, 0, 0);
	endtask
	task t_sense;
		wr(`RFD_OFS_SENSE_CFG, 32'h1f);
		cyc(2);
		chk("threshold", 32'hf, {28'h0, thr});
		chk("amp on", 32'h1, {31'h0, amp});
		pd <= 1'b1;
		cyc(2);
		chk("amp in power-down", 32'h0, {31'h0, amp});
		fon <= 1'b1;
		cyc(5);
		chk("irq", 32'h1, {31'h0, irq});
		cyc(5);
		chk("wake", 32'h1, {31'h0, wake});
		pd <= 1'b0;
		wr(`RFD_OFS_SENSE_CFG, 32'h00);
		cyc(2);
		chk("threshold", 32'h0, {28'h0, thr});
		chk("amp off", 32'h0, {31'h0, amp});
	endtask
	task t_detect;
		ac <= 1'b1;
		cyc(4);
		chk("run", 32'h1, {31'h0, run});
		wlock;
		chk("scheme 106", {30'h0, `RFD_SCH_106}, {30'h0, sc});
		fon <= 1'b0;
		cyc(10);
		chk("locked after field loss", 32'h0, {31'h0, lk});
		half <= 16'd32;
		fon <= 1'b1;
		wlock;
		chk("scheme 424", {30'h0, `RFD_SCH_424}, {30'h0, sc});
		fon <= 1'b0;
		cyc(10);
		half <= 16'd64;
		fon <= 1'b1;
		wlock;
		chk("scheme 212", {30'h0, `RFD_SCH_212}, {30'h0, sc});
		wr(`RFD_OFS_MODE, 32'h1);
		cyc(3);
		chk("run disabled", 32'h0, {31'h0, run});
		wr(`RFD_OFS_MODE, 32'h0);
		ac <= 1'b0;
		cyc(3);
		chk("run without command", 32'h0, {31'h0, run});
	endtask

	task end_of_test;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		cyc(20000);
		chk("watchdog", 32'h1, 32'h0);
		end_of_test;
	end
	initial begin
		cyc(2);
		rst <= 1'b0;
		cyc(1);
		t_regs;
		t_drive;
		t_force;
		t_sense;
		t_detect;
		end_of_test;
	end
endmodule
